// >>> mgmt_irq_pkg.sv
/*
 * package for the management interrupt status/enable aggregator: register
 * offsets, reset values, writable bit masks and the carrier structs.
 * assumes the register port carries 8-bit data at byte offsets.
 */
package mgmt_irq_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_PERIPH_A   = 8'h10;
    localparam logic [7:0] OFS_STATUS_PERIPH_B   = 8'h11;
    localparam logic [7:0] OFS_STATUS_PINS_A     = 8'h12;
    localparam logic [7:0] OFS_STATUS_PINS_B     = 8'h13;
    localparam logic [7:0] OFS_STATUS_PINS_FAN   = 8'h14;
    localparam logic [7:0] OFS_RESERVED_GAP      = 8'h15;
    localparam logic [7:0] OFS_ENABLE_PERIPH_A   = 8'h16;
    localparam logic [7:0] OFS_ENABLE_PERIPH_B   = 8'h17;

    // ----------------------------------------------------------------
    // reset values and implemented-bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_STATUS_PERIPH_A   = 8'h02;
    localparam logic [7:0] RST_ZERO              = 8'h00;
    localparam logic [7:0] MASK_PERIPH_A         = 8'hBE;
    localparam logic [7:0] MASK_PERIPH_B         = 8'h17;
    localparam logic [7:0] MASK_PINS_A           = 8'hF7;
    localparam logic [7:0] MASK_PINS_B           = 8'hFF;
    localparam logic [7:0] MASK_PINS_FAN         = 8'hCF;
    localparam logic [7:0] MASK_ENABLE_B         = 8'hF7;

    // ----------------------------------------------------------------
    // bit positions
    // ----------------------------------------------------------------
    localparam int BIT_PRINTER   = 1;
    localparam int BIT_SERIAL_B  = 2;
    localparam int BIT_SERIAL_A  = 3;
    localparam int BIT_FLOPPY    = 4;
    localparam int BIT_MIDI      = 5;
    localparam int BIT_WATCHDOG  = 7;
    localparam int BIT_MOUSE     = 0;
    localparam int BIT_KEYBOARD  = 1;
    localparam int BIT_INFRARED  = 2;
    localparam int BIT_KBC_GATE  = 4;
    localparam int BIT_TO_WAKE   = 5;
    localparam int BIT_TO_SERIRQ = 6;
    localparam int BIT_TO_PIN    = 7;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       watchdog;
        logic       midi_port;
        logic       floppy;
        logic       serial_a;
        logic       serial_b;
        logic       mouse;
        logic       keyboard;
        logic       kbc_gate;
    } periph_req_t;

    typedef struct packed {
        logic [7:0] pins_a;
        logic [7:0] pins_b;
        logic [7:0] pins_fan;
    } pin_event_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// >>> mgmt_irq_aggregator.sv
/*
 * management interrupt aggregator: five status registers, two enable
 * registers, one group interrupt routed to a pin, serial irq and wake logic.
 * assumes all inputs synchronous to clk; gpio/fan inputs are one-cycle event
 * pulses already qualified by their own edge logic; reset_n is the standby
 * power-on reset, main_reset_pulse covers main power, hard and soft resets.
 */
// How it works
// - periph_a resets 0x02; printer bit forced on resets
// - periph_a bits mirror sources, writes ignored
// - printer flag one while port inactive
// - active port: printer flag follows ack input
// - periph_a bit layout: serial, floppy, midi, watchdog
// - infrared flag set on any transition of the selected rx pin
// - reading periph_b clears infrared flag
// - mouse, keyboard, gate mirror sources in periph_b
// - pin status bits latch, write one clears
// - pins_a layout: gpio 20-22, 24-26, 60
// - pins_b layout: gpio 30-33, 41-43, 61
// - pins_fan: gpio 54-57, fan events 6,7
// - offset 15 reads zero
// - periph source counts only while its enable set; pin sources always count
// - enable bits share status bit positions
// - enable_b bit 5 routes group to wake
// - enable_b bit 6 routes group to serirq
// - enable_b bit 7 drives active-low pin
`timescale 1ns/1ps

module mgmt_irq_aggregator
    import mgmt_irq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        main_reset_pulse,
    input  wire reg_req_t    reg_req,
    output logic [7:0]       reg_rdata,
    input  wire periph_req_t periph_req,
    input  wire logic        printer_port_active,
    input  wire logic        printer_ack_input,
    input  wire logic        infrared_select,
    input  wire logic        serial_b_rx_pin,
    input  wire logic        infrared_rx_pin,
    input  wire pin_event_t  pin_event,
    output logic             group_mgmt_irq,
    output logic             mgmt_irq_pin_n,
    output logic             serirq_mgmt_req,
    output logic             power_wake_req
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] status_periph_a_q;
    logic [7:0] status_periph_b_q;
    logic [7:0] status_pins_a_q;
    logic [7:0] status_pins_b_q;
    logic [7:0] status_pins_fan_q;
    logic [7:0] enable_a_q;
    logic [7:0] enable_b_q;
    logic       ir_level_q;
    logic       ir_seen_q;
    logic       ir_sel_d;
    logic       group_d;

    // w1c update: a new event wins over a clear in the same cycle
    function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                            input logic [7:0] evt,
                                            input logic [7:0] clr,
                                            input logic [7:0] mask);
        w1c_next = ((cur & ~clr) | evt) & mask;
    endfunction

    function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction

    // ----------------------------------------------------------------
    // peripheral mirrors
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_periph_a_q <= RST_STATUS_PERIPH_A;
        end else begin
            // level mirror; no write path exists for these bits
            status_periph_a_q                <= RST_ZERO;
            status_periph_a_q[BIT_PRINTER]   <= main_reset_pulse || !printer_port_active
                                                || printer_ack_input;
            status_periph_a_q[BIT_SERIAL_B]  <= periph_req.serial_b;
            status_periph_a_q[BIT_SERIAL_A]  <= periph_req.serial_a;
            status_periph_a_q[BIT_FLOPPY]    <= periph_req.floppy;
            status_periph_a_q[BIT_MIDI]      <= periph_req.midi_port;
            status_periph_a_q[BIT_WATCHDOG]  <= periph_req.watchdog;
        end
    end

    // ----------------------------------------------------------------
    // infrared edge detect and periph_b
    // ----------------------------------------------------------------
    assign ir_sel_d = infrared_select ? infrared_rx_pin : serial_b_rx_pin;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ir_level_q <= 1'b0;
            ir_seen_q  <= 1'b0;
        end else begin
            ir_level_q <= ir_sel_d;
            ir_seen_q  <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_periph_b_q <= RST_ZERO;
        end else begin
            status_periph_b_q[7:5]           <= 3'h0;
            status_periph_b_q[3]             <= 1'b0;
            status_periph_b_q[BIT_MOUSE]     <= periph_req.mouse;
            status_periph_b_q[BIT_KEYBOARD]  <= periph_req.keyboard;
            status_periph_b_q[BIT_KBC_GATE]  <= periph_req.kbc_gate;
            // a transition in the read cycle still sets the flag
            if (ir_seen_q && (ir_sel_d != ir_level_q)) begin
                status_periph_b_q[BIT_INFRARED] <= 1'b1;
            end else if (reg_req.rd && reg_req.addr == OFS_STATUS_PERIPH_B) begin
                status_periph_b_q[BIT_INFRARED] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // latched pin events
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_pins_a_q   <= RST_ZERO;
            status_pins_b_q   <= RST_ZERO;
            status_pins_fan_q <= RST_ZERO;
        end else begin
            status_pins_a_q   <= w1c_next(status_pins_a_q, pin_event.pins_a,
                                 wr_hit(reg_req, OFS_STATUS_PINS_A) ? reg_req.wdata : RST_ZERO,
                                 MASK_PINS_A);
            status_pins_b_q   <= w1c_next(status_pins_b_q, pin_event.pins_b,
                                 wr_hit(reg_req, OFS_STATUS_PINS_B) ? reg_req.wdata : RST_ZERO,
                                 MASK_PINS_B);
            status_pins_fan_q <= w1c_next(status_pins_fan_q, pin_event.pins_fan,
                                 wr_hit(reg_req, OFS_STATUS_PINS_FAN) ? reg_req.wdata : RST_ZERO,
                                 MASK_PINS_FAN);
        end
    end

    // ----------------------------------------------------------------
    // enable registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_a_q <= RST_ZERO;
            enable_b_q <= RST_ZERO;
        end else begin
            if (wr_hit(reg_req, OFS_ENABLE_PERIPH_A)) begin
                enable_a_q <= reg_req.wdata & MASK_PERIPH_A;
            end
            if (wr_hit(reg_req, OFS_ENABLE_PERIPH_B)) begin
                enable_b_q <= reg_req.wdata & MASK_ENABLE_B;
            end
        end
    end

    // ----------------------------------------------------------------
    // group interrupt and routing
    // ----------------------------------------------------------------
    // pin-group enables live outside this block, so those sources always count
    assign group_d = |(status_periph_a_q & enable_a_q)
                   | |(status_periph_b_q & enable_b_q & MASK_PERIPH_B)
                   | |status_pins_a_q | |status_pins_b_q
                   | |status_pins_fan_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            group_mgmt_irq  <= 1'b0;
            mgmt_irq_pin_n  <= 1'b1;
            serirq_mgmt_req <= 1'b0;
            power_wake_req  <= 1'b0;
        end else begin
            group_mgmt_irq  <= group_d;
            power_wake_req  <= group_d && enable_b_q[BIT_TO_WAKE];
            serirq_mgmt_req <= group_d && enable_b_q[BIT_TO_SERIRQ];
            mgmt_irq_pin_n  <= !(group_d && enable_b_q[BIT_TO_PIN]);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= RST_ZERO;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_STATUS_PERIPH_A: reg_rdata <= status_periph_a_q;
                OFS_STATUS_PERIPH_B: reg_rdata <= status_periph_b_q;
                OFS_STATUS_PINS_A:   reg_rdata <= status_pins_a_q;
                OFS_STATUS_PINS_B:   reg_rdata <= status_pins_b_q;
                OFS_STATUS_PINS_FAN: reg_rdata <= status_pins_fan_q;
                OFS_RESERVED_GAP:    reg_rdata <= RST_ZERO;
                OFS_ENABLE_PERIPH_A: reg_rdata <= enable_a_q;
                OFS_ENABLE_PERIPH_B: reg_rdata <= enable_b_q;
                default:             reg_rdata <= RST_ZERO;
            endcase
        end else begin
            reg_rdata <= RST_ZERO;
        end
    end

endmodule

// >>> mgmt_irq_chk_asserts.sv
/* assertions on the management interrupt aggregator ports.
   assumes one clock domain, synchronous active-low reset. */
`timescale 1ns/1ps
module mgmt_irq_chk
    import mgmt_irq_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        main_reset_pulse,
    input wire reg_req_t    reg_req,
    input wire logic [7:0]  reg_rdata,
    input wire periph_req_t periph_req,
    input wire logic        printer_port_active,
    input wire logic        printer_ack_input,
    input wire logic        group_mgmt_irq,
    input wire logic        mgmt_irq_pin_n,
    input wire logic        serirq_mgmt_req,
    input wire logic        power_wake_req
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // mirrors need one live cycle before the read, hence the reset guard
    sequence s_rd(logic [7:0] a);
        reg_req.rd && reg_req.addr == a && $past(reset_n);
    endsequence
    property p_rst_val;
        reg_req.rd && reg_req.addr == OFS_STATUS_PERIPH_A && !$past(reset_n)
            |=> reg_rdata == RST_STATUS_PERIPH_A;
    endproperty
    property p_mirror_a;
        s_rd(OFS_STATUS_PERIPH_A) |=> (reg_rdata & 8'hFD) == {$past({periph_req.watchdog,
            1'b0, periph_req.midi_port, periph_req.floppy, periph_req.serial_a,
            periph_req.serial_b}, 2), 2'b00};
    endproperty
    property p_prn_idle;
        s_rd(OFS_STATUS_PERIPH_A) ##0 !$past(printer_port_active) |=> reg_rdata[1];
    endproperty
    property p_prn_ack;
        s_rd(OFS_STATUS_PERIPH_A) ##0 ($past(printer_port_active) && !$past(main_reset_pulse))
            |=> reg_rdata[1] == $past(printer_ack_input, 2);
    endproperty
    property p_mirror_b;
        s_rd(OFS_STATUS_PERIPH_B) |=> {reg_rdata[4], reg_rdata[1:0]}
            == $past({periph_req.kbc_gate, periph_req.keyboard, periph_req.mouse}, 2);
    endproperty
    property p_gap;
        reg_req.rd && reg_req.addr == OFS_RESERVED_GAP |=> reg_rdata == 8'h00;
    endproperty
    property p_rsvd_b;
        reg_req.rd && reg_req.addr == OFS_STATUS_PERIPH_B |=> (reg_rdata & ~MASK_PERIPH_B) == 8'h00;
    endproperty
    property p_pin_route;
        !mgmt_irq_pin_n |-> group_mgmt_irq || $past(group_mgmt_irq);
    endproperty
    property p_side_route;
        serirq_mgmt_req || power_wake_req |-> group_mgmt_irq || $past(group_mgmt_irq);
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("status a reset value wrong");
    a_mirror_a: assert property (p_mirror_a)
        else $error("status a does not mirror sources");
    a_prn_idle: assert property (p_prn_idle)
        else $error("printer flag low while port inactive");
    a_prn_ack: assert property (p_prn_ack)
        else $error("printer flag not following ack");
    a_mirror_b: assert property (p_mirror_b)
        else $error("status b does not mirror sources");
    a_gap: assert property (p_gap)
        else $error("gap location read nonzero");
    a_rsvd_b: assert property (p_rsvd_b)
        else $error("status b reserved bits nonzero");
    a_pin_route: assert property (p_pin_route)
        else $error("pin low without group interrupt");
    a_side_route: assert property (p_side_route)
        else $error("route output without group interrupt");
endmodule
bind mgmt_irq_aggregator mgmt_irq_chk u_chk (.clk(clk), .reset_n(reset_n),
    .main_reset_pulse(main_reset_pulse), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .periph_req(periph_req), .printer_port_active(printer_port_active),
    .printer_ack_input(printer_ack_input), .group_mgmt_irq(group_mgmt_irq),
    .mgmt_irq_pin_n(mgmt_irq_pin_n), .serirq_mgmt_req(serirq_mgmt_req),
    .power_wake_req(power_wake_req));

// >>> host_model.sv
/* host software model: one register access at a time.
   assumes read data stands only in the cycle after the read strobe. */
`timescale 1ns/1ps
module host_model
    import mgmt_irq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output reg_req_t        reg_req
);
    initial reg_req = '0;
    // idle lines carry the inverse of the last value, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule

// >>> mgmt_irq_aggregator_bench.sv
/* self-checking bench for the management interrupt aggregator.
   assumes the host model owns the register port. */
`timescale 1ns/1ps
module mgmt_irq_aggregator_bench
    import mgmt_irq_pkg::*;
;
    logic        clk = 1'b0, reset_n = 1'b0, mrst = 1'b0, active = 1'b0, ack = 1'b0;
    logic        ir_sel = 1'b0, rxb = 1'b0, rxi = 1'b0, grp, pin_n, serirq, wake;
    logic [7:0]  reg_rdata, d;
    reg_req_t    reg_req;
    periph_req_t periph_req = '0;
    pin_event_t  pin_event = '0;
    int          n_fail = 0, checks = 0, i;
    int          pos[8] = '{BIT_KBC_GATE, BIT_KEYBOARD, BIT_MOUSE, BIT_SERIAL_B,
                            BIT_SERIAL_A, BIT_FLOPPY, BIT_MIDI, BIT_WATCHDOG};
    initial forever #10 clk = ~clk;
    host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    mgmt_irq_aggregator dut (.clk(clk), .reset_n(reset_n), .main_reset_pulse(mrst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .periph_req(periph_req),
        .printer_port_active(active), .printer_ack_input(ack), .infrared_select(ir_sel),
        .serial_b_rx_pin(rxb), .infrared_rx_pin(rxi), .pin_event(pin_event),
        .group_mgmt_irq(grp), .mgmt_irq_pin_n(pin_n), .serirq_mgmt_req(serirq),
        .power_wake_req(wake));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask
    // group, pin asserted, serial irq, wake; outputs lag the enable write by one cycle
    task automatic outs_chk(input logic [7:0] exp);
        // look mid-cycle so the outputs launched at the last edge have settled
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({4'h0, grp, ~pin_n, serirq, wake}, exp);
    endtask
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(20 * 5000);
        n_fail++;
        results();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        fork
            @(posedge clk) reset_n <= 1'b1;
            rd_chk(OFS_STATUS_PERIPH_A, RST_STATUS_PERIPH_A);
        join
        for (i = 0; i < 8; i++) begin
            @(posedge clk) periph_req <= periph_req_t'(8'h01 << i);
            host.wr(OFS_STATUS_PERIPH_A, 8'h00);
            rd_chk(OFS_STATUS_PERIPH_A, (i > 2) ? 8'(8'h02 | 1 << pos[i]) : 8'h02);
            host.wr(OFS_STATUS_PERIPH_B, 8'hFF);
            rd_chk(OFS_STATUS_PERIPH_B, (i < 3) ? 8'(1 << pos[i]) : 8'h00);
        end
        @(posedge clk) periph_req <= '0;
        rd_chk(OFS_STATUS_PERIPH_A, 8'h02);
        $display("test mirrors done");
        for (i = 0; i < 3; i++) begin
            @(posedge clk) {mrst, ack} <= 2'(i);
            active <= 1'b1;
            rd_chk(OFS_STATUS_PERIPH_A, (i != 0) ? 8'h02 : 8'h00);
        end
        @(posedge clk) {mrst, active} <= 2'b00;
        host.wr(OFS_ENABLE_PERIPH_A, 8'hFF);
        rd_chk(OFS_ENABLE_PERIPH_A, MASK_PERIPH_A);
        host.wr(OFS_ENABLE_PERIPH_B, 8'hFF);
        rd_chk(OFS_ENABLE_PERIPH_B, MASK_ENABLE_B);
        outs_chk(8'h0F);
        host.wr(OFS_ENABLE_PERIPH_A, 8'h00);
        outs_chk(8'h00);
        host.wr(OFS_ENABLE_PERIPH_A, 8'h02);
        for (i = 5; i < 8; i++) begin
            host.wr(OFS_ENABLE_PERIPH_B, 8'(1 << i));
            outs_chk(8'(8'h08 | 1 << (i - 5)));
        end
        host.wr(OFS_ENABLE_PERIPH_A, 8'h00);
        host.wr(OFS_ENABLE_PERIPH_B, 8'hE4);
        $display("test printer and routing done");
        @(posedge clk) ir_sel <= 1'b1;
        @(posedge clk) rxi <= 1'b1;
        rd_chk(OFS_STATUS_PERIPH_B, 8'h04);
        rd_chk(OFS_STATUS_PERIPH_B, 8'h00);
        @(posedge clk) rxb <= 1'b1;
        rd_chk(OFS_STATUS_PERIPH_B, 8'h00);
        @(posedge clk) rxi <= 1'b0;
        outs_chk(8'h0F);
        host.rd(OFS_STATUS_PERIPH_B, d);
        outs_chk(8'h00);
        $display("test infrared done");
        @(posedge clk) pin_event <= '1;
        @(posedge clk) pin_event <= '0;
        rd_chk(OFS_STATUS_PINS_A, MASK_PINS_A);
        rd_chk(OFS_STATUS_PINS_B, MASK_PINS_B);
        rd_chk(OFS_STATUS_PINS_FAN, MASK_PINS_FAN);
        outs_chk(8'h0F);
        host.wr(OFS_STATUS_PINS_A, 8'h01);
        rd_chk(OFS_STATUS_PINS_A, 8'hF6);
        for (i = 0; i < 3; i++) begin
            host.wr(8'(OFS_STATUS_PINS_A + i), 8'hFF);
        end
        rd_chk(OFS_STATUS_PINS_FAN, 8'h00);
        outs_chk(8'h00);
        host.wr(OFS_RESERVED_GAP, 8'hFF);
        rd_chk(OFS_RESERVED_GAP, 8'h00);
        rd_chk(8'h30, 8'h00);
        $display("test pin events done");
        results();
    end
endmodule
